// ---- logic/spc_defines.vh ----
// Purpose: Constants for the sample clock PLL control block.
// Assumes: APB byte addresses are four times the printed register index.
// Notes: Timing counts derive from the 250 MHz bus clock.
`ifndef SPC_DEFINES_VH
`define SPC_DEFINES_VH
`define SPC_IDX_CTRL_ONE 8'h00
`define SPC_IDX_CTRL_THREE 8'h02
`define SPC_IDX_CTRL_FOUR 8'h03
`define SPC_IDX_LOCK_STAT 8'h1B
`define SPC_IDX_IRQ_STAT 8'h20
`define SPC_IDX_IRQ_MASK 8'h21
`define SPC_BIT_VCO_CAL 24
`define SPC_BIT_DAC_CAL 24
`define SPC_BIT_LOCK 24
`define SPC_BIT_PLL_EN 18
`define SPC_BIT_MAN_CP 6
`define SPC_FB_DIV_MSB 15
`define SPC_FB_DIV_LSB 8
`define SPC_CP_MSB 5
`define SPC_CP_LSB 3
`define SPC_FB_DIV_MIN 8'h0A
`define SPC_CP_DEFAULT 3'h3
`define SPC_FB_DIV_RESET 8'h19
`define SPC_DAC_CAL_PERIODS 469632
`define SPC_VCO_CAL_CYCLES 1024
`define SPC_LOCK_DELAY_CYCLES 256
`endif

// ---- logic/spc_top.v ----
// Purpose: Sample clock PLL control: path select, divider, calibration sequencing, lock status.
// Assumes: APB slave on pclk; analog PLL modelled by calibration and lock timers.
// Notes: Interrupt status clears on read; irq is the OR of unmasked status bits.
`include "spc_defines.vh"
`timescale 1ns/100ps
`default_nettype none
module spc_top #(
  parameter DAC_CAL_CYCLES = `SPC_DAC_CAL_PERIODS,
  parameter VCO_CAL_CYCLES = `SPC_VCO_CAL_CYCLES,
  parameter LOCK_CYCLES = `SPC_LOCK_DELAY_CYCLES
) (
  // Clock and reset.
  input wire pclk,
  input wire presetn,
  // APB slave.
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Reference clock stable indication from the pin.
  input wire ref_clk_valid,
  // Clock control outputs.
  output reg pll_path_sel,
  output reg [8:0] pll_multiplier,
  output reg [2:0] charge_pump_current_code,
  output reg vco_cal_busy,
  output reg dac_cal_busy,
  output reg irq
);
  // ==========================================================================
  // Registers and decode.
  // ==========================================================================
  reg [31:0] function_control_one;
  reg [31:0] function_control_three;
  reg [31:0] function_control_four;
  reg [2:0] irq_stat;
  reg [2:0] irq_mask;
  reg ref_meta;
  reg ref_sync;
  reg vco_en_d;
  reg dac_en_d;
  reg [2:0] auto_cp;
  reg [31:0] vco_cnt;
  reg [31:0] dac_cnt;
  reg [31:0] lock_cnt;
  reg locked;
  wire [9:0] idx;
  wire acc;
  wire wr;
  wire rd;
  wire mapped;
  wire vco_start;
  wire dac_start;
  wire vco_done;
  wire dac_done;
  wire lock_rise;
  wire stat_rd;
  wire [7:0] fb_div;
  wire [7:0] wr_div;
  reg [31:0] next_rdata;

  assign idx = paddr[11:2];
  assign acc = psel & penable & ~pready;
  assign wr = acc & pwrite;
  assign rd = acc & ~pwrite;
  assign mapped = (idx == {2'h0, `SPC_IDX_CTRL_ONE}) || (idx == {2'h0, `SPC_IDX_CTRL_THREE}) ||
                  (idx == {2'h0, `SPC_IDX_CTRL_FOUR}) || (idx == {2'h0, `SPC_IDX_LOCK_STAT}) ||
                  (idx == {2'h0, `SPC_IDX_IRQ_STAT}) || (idx == {2'h0, `SPC_IDX_IRQ_MASK});
  assign fb_div = function_control_three[`SPC_FB_DIV_MSB:`SPC_FB_DIV_LSB];
  assign wr_div = pwdata[`SPC_FB_DIV_MSB:`SPC_FB_DIV_LSB];
  assign vco_start = function_control_one[`SPC_BIT_VCO_CAL] & ~vco_en_d & ref_sync;
  assign dac_start = function_control_four[`SPC_BIT_DAC_CAL] & ~dac_en_d;
  assign vco_done = vco_cal_busy && (vco_cnt == 32'h0000_0001);
  assign dac_done = dac_cal_busy && (dac_cnt == 32'h0000_0001);
  assign lock_rise = pll_path_sel && !locked && !vco_cal_busy && !vco_start && (lock_cnt == 32'h0000_0001);
  assign stat_rd = rd && (idx == {2'h0, `SPC_IDX_IRQ_STAT});

  // ==========================================================================
  // APB access and configuration registers.
  // ==========================================================================
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      function_control_one <= 32'h0000_0000;
      function_control_three <= {16'h0000, `SPC_FB_DIV_RESET, 2'h0, `SPC_CP_DEFAULT, 3'h0};
      function_control_four <= 32'h0000_0000;
      irq_mask <= 3'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= acc;
      pslverr <= acc & ~mapped;
      if (rd) begin
        prdata <= next_rdata;
      end
      if (wr) begin
        case (idx)
          {2'h0, `SPC_IDX_CTRL_ONE}: begin
            function_control_one <= pwdata;
          end
          {2'h0, `SPC_IDX_CTRL_THREE}: begin
            function_control_three <= pwdata;
            if (wr_div < `SPC_FB_DIV_MIN) begin
              function_control_three[`SPC_FB_DIV_MSB:`SPC_FB_DIV_LSB] <= `SPC_FB_DIV_MIN;
            end
          end
          {2'h0, `SPC_IDX_CTRL_FOUR}: begin
            function_control_four <= pwdata;
          end
          {2'h0, `SPC_IDX_IRQ_MASK}: begin
            irq_mask <= pwdata[2:0];
          end
          default: begin
          end
        endcase
      end
    end
  end

  always @* begin
    next_rdata = 32'h0000_0000;
    case (idx)
      {2'h0, `SPC_IDX_CTRL_ONE}: begin
        next_rdata = function_control_one;
      end
      {2'h0, `SPC_IDX_CTRL_THREE}: begin
        next_rdata = function_control_three;
      end
      {2'h0, `SPC_IDX_CTRL_FOUR}: begin
        next_rdata = function_control_four;
      end
      {2'h0, `SPC_IDX_LOCK_STAT}: begin
        next_rdata[`SPC_BIT_LOCK] = locked & pll_path_sel;
        next_rdata[1] = dac_cal_busy;
        next_rdata[0] = vco_cal_busy;
      end
      {2'h0, `SPC_IDX_IRQ_STAT}: begin
        next_rdata[2:0] = irq_stat;
      end
      {2'h0, `SPC_IDX_IRQ_MASK}: begin
        next_rdata[2:0] = irq_mask;
      end
      default: begin
      end
    endcase
  end

  // ==========================================================================
  // PLL path, multiplier and charge pump selection.
  // ==========================================================================
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_path_sel <= 1'b0;
      pll_multiplier <= 9'h000;
      charge_pump_current_code <= `SPC_CP_DEFAULT;
      auto_cp <= `SPC_CP_DEFAULT;
      ref_meta <= 1'b0;
      ref_sync <= 1'b0;
    end else begin
      ref_meta <= ref_clk_valid;
      ref_sync <= ref_meta;
      pll_path_sel <= function_control_three[`SPC_BIT_PLL_EN];
      pll_multiplier <= {fb_div, 1'b0};
      if (vco_start) begin
        // Calibration picks a current from the divider range.
        if (fb_div < 8'h10) auto_cp <= 3'h0;
        else if (fb_div < 8'h18) auto_cp <= 3'h1;
        else if (fb_div < 8'h24) auto_cp <= 3'h2;
        else if (fb_div < 8'h2C) auto_cp <= 3'h3;
        else if (fb_div < 8'h38) auto_cp <= 3'h4;
        else if (fb_div < 8'h40) auto_cp <= 3'h5;
        else if (fb_div < 8'h50) auto_cp <= 3'h6;
        else auto_cp <= 3'h7;
      end
      if (function_control_three[`SPC_BIT_MAN_CP]) begin
        charge_pump_current_code <= function_control_three[`SPC_CP_MSB:`SPC_CP_LSB];
      end else begin
        charge_pump_current_code <= auto_cp;
      end
    end
  end

  // ==========================================================================
  // VCO and DAC calibration timers and lock.
  // ==========================================================================
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vco_en_d <= 1'b0;
      dac_en_d <= 1'b0;
      vco_cal_busy <= 1'b0;
      dac_cal_busy <= 1'b0;
      vco_cnt <= 32'h0000_0000;
      dac_cnt <= 32'h0000_0000;
      lock_cnt <= 32'h0000_0000;
      locked <= 1'b0;
    end else begin
      vco_en_d <= function_control_one[`SPC_BIT_VCO_CAL] & (vco_en_d | ref_sync);
      dac_en_d <= function_control_four[`SPC_BIT_DAC_CAL];
      if (vco_start) begin
        vco_cal_busy <= 1'b1;
        vco_cnt <= VCO_CAL_CYCLES;
        locked <= 1'b0;
      end else if (vco_cal_busy) begin
        vco_cnt <= vco_cnt - 32'h0000_0001;
        if (vco_done) begin
          vco_cal_busy <= 1'b0;
          lock_cnt <= LOCK_CYCLES;
        end
      end else if (!pll_path_sel) begin
        locked <= 1'b0;
        lock_cnt <= 32'h0000_0000;
      end else if (lock_cnt != 32'h0000_0000) begin
        lock_cnt <= lock_cnt - 32'h0000_0001;
        if (lock_cnt == 32'h0000_0001) begin
          locked <= 1'b1;
        end
      end
      if (dac_start) begin
        dac_cal_busy <= 1'b1;
        dac_cnt <= DAC_CAL_CYCLES;
      end else if (dac_cal_busy) begin
        dac_cnt <= dac_cnt - 32'h0000_0001;
        if (dac_done) begin
          dac_cal_busy <= 1'b0;
        end
      end
    end
  end

  // ==========================================================================
  // Interrupts: bit0 VCO cal done, bit1 DAC cal done, bit2 lock gained.
  // ==========================================================================
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= 3'h0;
      irq <= 1'b0;
    end else begin
      irq_stat <= (irq_stat & {3{~stat_rd}}) | {lock_rise, dac_done, vco_done};
      irq <= |(irq_stat & irq_mask);
    end
  end
endmodule // spc_top
`default_nettype wire

// ---- sim/spc_top_sva.sv ----
// Purpose: Port assertions for the sample clock PLL control block.
// Assumes: Byte addresses are four times the register index.
// Notes: Calibration lengths follow the bound parameters.
`timescale 1ns/100ps
`default_nettype none
module spc_top_sva #(parameter DAC_CAL_CYCLES = 20, parameter VCO_CAL_CYCLES = 16) (
  // Clock, reset and bus.
  input wire logic pclk, presetn, psel, penable, pwrite, pready, pslverr,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  // Clock control.
  input wire logic pll_path_sel, vco_cal_busy, dac_cal_busy, irq,
  input wire logic [8:0] pll_multiplier,
  input wire logic [2:0] charge_pump_current_code
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [8:0] em;
  logic ep;
  logic [2:0] ec;
  logic [19:0] vc, dc;
  wire acc = psel && penable && pready;
  wire wr3 = acc && pwrite && paddr == 12'h008;
  wire hit = paddr == 12'h000 || paddr == 12'h008 || paddr == 12'h00C || paddr == 12'h06C;
  wire map = hit || paddr == 12'h080 || paddr == 12'h084;
  always_ff @(posedge pclk) begin
    if (wr3) begin
      em <= (pwdata[15:8] < 8'h0A) ? 9'h014 : {pwdata[15:8], 1'b0};
      ep <= pwdata[18];
      ec <= pwdata[5:3];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vc <= 20'h0;
      dc <= 20'h0;
    end else begin
      vc <= vco_cal_busy ? vc + 20'h1 : 20'h0;
      dc <= dac_cal_busy ? dc + 20'h1 : 20'h0;
    end
  end
  AST_PATH: assert property (wr3 |-> ##[1:3] pll_path_sel == ep) else $error("Path select wrong.");
  AST_EVEN: assert property (pll_multiplier != 9'h000 |-> !pll_multiplier[0] && pll_multiplier >= 9'h014)
    else $error("Multiplier odd or low.");
  AST_MULT: assert property (wr3 |-> ##[1:3] pll_multiplier == em) else $error("Multiplier wrong.");
  AST_CPMAN: assert property (wr3 && pwdata[6] |-> ##[1:3] charge_pump_current_code == ec)
    else $error("Manual pump code ignored.");
  AST_LOCK: assert property (acc && !pwrite && paddr == 12'h06C && prdata[24] |-> pll_path_sel)
    else $error("Lock shown without PLL path.");
  AST_VCOLEN: assert property ($fell(vco_cal_busy) |-> vc == VCO_CAL_CYCLES) else $error("VCO cal length.");
  AST_DACLEN: assert property ($fell(dac_cal_busy) |-> dc == DAC_CAL_CYCLES) else $error("DAC cal length.");
  AST_HOLD: assert property ($fell(vco_cal_busy) |=> !vco_cal_busy [*8]) else $error("VCO cal restarted.");
  AST_ERR: assert property (acc |-> pslverr == !map) else $error("Error response wrong.");
  AST_WAIT: assert property (psel && penable && !pready |=> pready) else $error("Answer late.");
  C_VCO: cover property ($rose(vco_cal_busy));
  C_DAC: cover property ($rose(dac_cal_busy));
  C_ERR: cover property (acc && pslverr);
endmodule // spc_top_sva
bind spc_top spc_top_sva #(.DAC_CAL_CYCLES(DAC_CAL_CYCLES), .VCO_CAL_CYCLES(VCO_CAL_CYCLES)) u_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready),
  .pslverr(pslverr), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pll_path_sel(pll_path_sel),
  .vco_cal_busy(vco_cal_busy), .dac_cal_busy(dac_cal_busy), .irq(irq), .pll_multiplier(pll_multiplier),
  .charge_pump_current_code(charge_pump_current_code));
`default_nettype wire

// ---- sim/spc_ref_src.sv ----
// Purpose: Reference clock source that reports stable after settling.
// Assumes: One pclk domain.
// Notes: Stability drops on the next pclk edge after switching off.
`timescale 1ns/100ps
`default_nettype none
module spc_ref_src #(parameter int SETTLE = 6) (
  input wire logic pclk,
  input wire logic src_on,
  output wire logic ref_clk_valid
);
  int cnt = 0;
  logic ok = 1'b0;
  assign ref_clk_valid = ok;
  always @(posedge pclk) begin
    cnt <= src_on ? cnt + 1 : 0;
    ok <= src_on && cnt >= SETTLE;
  end
endmodule // spc_ref_src
`default_nettype wire

// ---- sim/tb.sv ----
// Purpose: Self-checking bench for the sample clock PLL control block.
// Assumes: One wait state per APB access.
// Notes: Short calibration counts keep the run brief.
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam int DAC = 20;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, src_on = 1'b0, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, ref_ok, pll_path_sel, vco_cal_busy, dac_cal_busy, irq, ib;
  logic [8:0] pll_multiplier;
  logic [2:0] charge_pump_current_code;
  logic [7:0] dv [4] = '{8'h0A, 8'hFF, 8'h05, 8'h19};
  int n_mismatch = 0, samples_checked = 0, k, bc = 0;
  always #2 pclk = ~pclk;
  always @(posedge pclk) bc <= bc + (dac_cal_busy === 1'b1);
  spc_top #(.DAC_CAL_CYCLES(DAC), .VCO_CAL_CYCLES(16), .LOCK_CYCLES(4)) DUT (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ref_clk_valid(ref_ok), .pll_path_sel(pll_path_sel),
    .pll_multiplier(pll_multiplier), .charge_pump_current_code(charge_pump_current_code),
    .vco_cal_busy(vco_cal_busy), .dac_cal_busy(dac_cal_busy), .irq(irq));
  spc_ref_src #(.SETTLE(6)) u_ref (.pclk(pclk), .src_on(src_on), .ref_clk_valid(ref_ok));
  task test_done;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin n_mismatch++; test_done; end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task waitsig(input int s, input logic lv);
    for (k = 0; (s == 0 ? vco_cal_busy : s == 1 ? dac_cal_busy : ref_ok) !== lv; k++) begin
      if (k > 300) begin n_mismatch++; test_done; end
      @(posedge pclk);
    end
  endtask
  function automatic logic [31:0] cfg3(input logic pe, input logic [7:0] n, input logic m, input logic [2:0] c);
    return {13'h0, pe, 2'h0, n, 1'b0, m, c, 3'h0};
  endfunction
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 12'h008, 0);
    chk(rd & 32'h0000FF38, 32'h00001918);
    chk(charge_pump_current_code, 3'h3);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      apb(1, 12'h008, cfg3(i[0], dv[i], 0, 0));
      repeat (3) @(posedge pclk);
      chk(pll_multiplier, 2 * (dv[i] < 10 ? 10 : dv[i]));
      chk(pll_path_sel, i[0]);
    end
    for (int c = 0; c < 8; c++) begin
      apb(1, 12'h008, cfg3(1, 8'h19, 1, c[2:0]));
      repeat (3) @(posedge pclk);
      chk(charge_pump_current_code, c);
    end
    apb(1, 12'h008, cfg3(1, 8'h0C, 1, 3'h0));
    repeat (3) @(posedge pclk);
    chk(charge_pump_current_code, 3'h0);
    $display("test divider and pump done");
    apb(1, 12'h008, cfg3(1, 8'h19, 0, 0));
    apb(1, 12'h084, 0);
    src_on <= 1'b1;
    waitsig(2, 1);
    apb(1, 12'h000, 32'h01000000);
    waitsig(0, 1);
    waitsig(0, 0);
    rd = 0;
    for (k = 0; k < 20 && rd[24] !== 1'b1; k++) apb(0, 12'h06C, 0);
    chk(rd[24], 1);
    chk(charge_pump_current_code, 3'h2);
    chk(irq, 0);
    apb(1, 12'h084, 32'hFFFFFFFF);
    repeat (3) @(posedge pclk);
    ib = irq;
    apb(0, 12'h080, 0);
    chk(ib, 1);
    chk(rd, 32'h0000_0005);
    repeat (3) @(posedge pclk);
    chk(irq, 0);
    apb(1, 12'h000, 32'h01000000);
    repeat (10) @(posedge pclk);
    chk(vco_cal_busy, 0);
    apb(1, 12'h000, 0);
    apb(1, 12'h000, 32'h01000000);
    waitsig(0, 1);
    waitsig(0, 0);
    apb(1, 12'h008, cfg3(0, 8'h19, 0, 0));
    repeat (3) @(posedge pclk);
    apb(0, 12'h06C, 0);
    chk(rd[24], 0);
    $display("test vco calibration done");
    apb(1, 12'h00C, 32'h01000000);
    apb(1, 12'h00C, 0);
    waitsig(1, 1);
    waitsig(1, 0);
    chk(bc, DAC);
    apb(0, 12'h0FC, 0);
    chk(er, 1);
    chk(rd, 0);
    $display("test dac and unmapped done");
    test_done;
  end
endmodule // tb
`default_nettype wire
